// File: dv/testbench.sv
/*
  Self-checking bench for the rotate/subtract datapath slice.
  It reaches the accumulator, flags and file registers through AHB-Lite single-word transfers.
  It assumes one slave, with hready taken from hreadyout, and that each transfer has one wait state.
*/
`define CHK(nm, exp, got) begin numChecks++; if ((got) !== (exp)) begin fails++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TIMEOUT_CYCLES = 5000;

  logic sys_clk;
  logic reset;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  wire logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  int fails;
  int numChecks;
  int cycles = 0;

  rsa_alu_top i_dut (
    .sys_clk(sys_clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp)
  );

  // With a single slave, its hreadyout is the bus's hready
  assign hready = hreadyout;

  always #12.5 sys_clk = ~sys_clk;

  task automatic end_sim();
    if (fails == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYCLES) begin
      fails++;
      end_sim();
    end
  end

  // The address phase is held until hready is seen high, and the data phase is then held the same way
  task automatic busXfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0000_0000;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : busXfer

  task automatic busWrite(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    busXfer(1'b1, a, d, dummy);
  endtask : busWrite

  task automatic chkReg(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    busXfer(1'b0, a, 32'h0000_0000, v);
    `CHK(nm, exp, v)
  endtask : chkReg

  function automatic logic [31:0] fileAdr(input logic [6:0] idx);
    return 32'h0000_0200 + {23'h0, idx, 2'b00};
  endfunction : fileAdr

  localparam logic [31:0] A_INSTR = 32'(rsa_pkg::OFS_INSTR);
  localparam logic [31:0] A_ACC = 32'(rsa_pkg::OFS_ACC);
  localparam logic [31:0] A_FLAGS = 32'(rsa_pkg::OFS_FLAGS);
  localparam logic [31:0] A_COUNT = 32'(rsa_pkg::OFS_COUNT);
  localparam logic [31:0] A_LAST = 32'(rsa_pkg::OFS_LAST);

  // Rotate cases: right, dest, file index, file value, carry in
  logic rotRight[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic rotDest[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [6:0] rotIdx[4] = '{7'h00, 7'h2D, 7'h5A, 7'h7F};
  logic [7:0] rotVal[4] = '{8'hE6, 8'hE6, 8'h80, 8'h01};
  logic rotCin[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  // Subtract cases: literal, accumulator
  logic [7:0] subLit[6] = '{8'h02, 8'h02, 8'h02, 8'h10, 8'h85, 8'h00};
  logic [7:0] subAcc[6] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h85, 8'hFF};

  initial begin
    logic [7:0] res;
    logic nc;
    logic [2:0] fl;
    sys_clk = 1'b0;
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0000_0000;
    fails = 0;
    numChecks = 0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chkReg("acc reset", A_ACC, 32'h0000_0000);
    chkReg("flags reset", A_FLAGS, 32'h0000_0000);
    chkReg("count reset", A_COUNT, 32'h0000_0000);
    chkReg("instr reset", A_INSTR, 32'h0000_0000);
    chkReg("unmapped", 32'h0000_0014, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      busWrite(fileAdr(rotIdx[i]), {24'h0, rotVal[i]});
      busWrite(A_ACC, 32'h0000_005A);
      // Nibble carry and zero are preset high so that a rotate touching them shows up
      busWrite(A_FLAGS, {29'h0, 2'b11, rotCin[i]});
      res = rotRight[i] ? {rotCin[i], rotVal[i][7:1]} : {rotVal[i][6:0], rotCin[i]};
      nc = rotRight[i] ? rotVal[i][0] : rotVal[i][7];
      busWrite(A_INSTR, {18'h0, rotRight[i] ? rsa_pkg::OPC_ROR : rsa_pkg::OPC_ROL, rotDest[i], rotIdx[i]});
      chkReg("rot acc", A_ACC, {24'h0, rotDest[i] ? 8'h5A : res});
      chkReg("rot file", fileAdr(rotIdx[i]), {24'h0, rotDest[i] ? res : rotVal[i]});
      chkReg("rot flags", A_FLAGS, {29'h0, 2'b11, nc});
    end
    for (int i = 0; i < 6; i++) begin
      res = subLit[i] - subAcc[i];
      fl = {res == 8'h00, subLit[i][3:0] >= subAcc[i][3:0], subLit[i] >= subAcc[i]};
      // The literal's low bits and bit 7 look like a file index and destination, so that file must survive
      busWrite(fileAdr(subLit[i][6:0]), 32'h0000_00A5);
      busWrite(A_ACC, {24'h0, subAcc[i]});
      busWrite(A_FLAGS, {29'h0, ~fl});
      busWrite(A_INSTR, {18'h0, rsa_pkg::OPC_SUB, i[0], subLit[i]});
      chkReg("sub acc", A_ACC, {24'h0, res});
      chkReg("sub flags", A_FLAGS, {29'h0, fl});
      chkReg("sub file", fileAdr(subLit[i][6:0]), 32'h0000_00A5);
      chkReg("sub last", A_LAST, {21'h00_0000, 1'h0, rsa_pkg::OP_SUB, res});
    end
    // An instruction that matches no pattern leaves the accumulator and the count alone
    busWrite(A_INSTR, 32'h0000_0000);
    chkReg("nop acc", A_ACC, {24'h0, subLit[5] - subAcc[5]});
    // Unsupported pattern: bad bit set, no operation, zero result
    chkReg("nop last", A_LAST, 32'h0000_0400);
    // The count is read-only, so this write must be ignored
    busWrite(A_COUNT, 32'h0000_FFFF);
    chkReg("op count", A_COUNT, 32'h0000_000A);
    end_sim();
  end
endmodule : testbench

// File: inc/rsa_pkg.sv
/*
  Constants, types and helpers shared by the rotate/subtract datapath slice:
  the register map, the instruction fields, the opcode patterns and reset values.
  Assumes a 14-bit instruction word and an 8-bit accumulator and file registers.
*/
// Summary of operation
// - Left rotate moves carry into bit 0
// - Right rotate moves carry into bit 7
// - Destination bit picks accumulator or file register
// - Subtract computes literal minus accumulator, two's complement
// - Subtract result always to accumulator only
// - Rotates change only the carry flag
package rsa_pkg;

  // Register map, byte addresses within the slave
  localparam logic [11:0] OFS_INSTR = 12'h000;
  localparam logic [11:0] OFS_ACC = 12'h004;
  localparam logic [11:0] OFS_FLAGS = 12'h008;
  localparam logic [11:0] OFS_LAST = 12'h00C;
  localparam logic [11:0] OFS_COUNT = 12'h010;
  localparam logic [2:0] FILE_PAGE = 3'h1;
  localparam int FILE_PAGE_LSB = 9;
  localparam int FILE_IDX_MSB = 8;
  localparam int FILE_IDX_LSB = 2;
  localparam int FILE_DEPTH = 128;

  // Instruction fields
  localparam int OPC_MSB = 13;
  localparam int OPC_ROT_LSB = 8;
  localparam int OPC_SUB_LSB = 9;
  localparam int DEST_BIT = 7;
  localparam int FILE_MSB = 6;
  localparam int LIT_MSB = 7;
  localparam logic [5:0] OPC_ROL = 6'h0D;
  localparam logic [5:0] OPC_ROR = 6'h0C;
  localparam logic [4:0] OPC_SUB = 5'h1E;

  // Flag positions in the flags register
  localparam int FLAG_C = 0;
  localparam int FLAG_NIBBLE = 1;
  localparam int FLAG_Z = 2;

  // Fields of the last-result register
  localparam int LAST_OP_LSB = 8;
  localparam int LAST_BAD_BIT = 10;

  // Reset values
  localparam logic [13:0] RST_INSTR = 14'h0000;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  // Bus encodings
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic RESP_OKAY = 1'b0;

  typedef enum logic [1:0] {OP_NONE, OP_ROL, OP_ROR, OP_SUB} rsa_op_t;
  typedef enum logic {BUS_IDLE, BUS_ACCESS} rsa_bus_t;
  typedef enum logic {EXE_IDLE, EXE_RUN} rsa_exe_t;

  function automatic logic fileHit(input logic [11:0] addr);
    return addr[11:FILE_PAGE_LSB] == FILE_PAGE;
  endfunction : fileHit

  function automatic logic [6:0] fileIdx(input logic [11:0] addr);
    return addr[FILE_IDX_MSB:FILE_IDX_LSB];
  endfunction : fileIdx

endpackage : rsa_pkg

// File: logic/rsa_alu.sv
/*
  Combinational datapath: rotate through carry and literal-minus-accumulator.
  Assumes the caller applies the results only for the flags each op owns.
*/
module rsa_alu (
  input wire rsa_pkg::rsa_op_t opKind,
  input wire logic [7:0] fileVal,
  input wire logic [7:0] accVal,
  input wire logic [7:0] literal,
  input wire logic carryIn,
  output logic [7:0] result,
  output logic carryOut,
  output logic nibbleOut,
  output logic zeroOut
);

  // Top bit of the widened difference is the borrow
  function automatic logic [8:0] subWide(input logic [7:0] a, input logic [7:0] b);
    return {1'b0, a} - {1'b0, b};
  endfunction : subWide

  logic [8:0] byteDiff;
  logic [8:0] nibDiff;

  assign byteDiff = subWide(literal, accVal);
  assign nibDiff = subWide({4'h0, literal[3:0]}, {4'h0, accVal[3:0]});

  always_comb begin
    result = 8'h00;
    carryOut = carryIn;
    nibbleOut = 1'b0;
    zeroOut = 1'b0;
    case (opKind)
      rsa_pkg::OP_ROL: begin
        result = {fileVal[6:0], carryIn};
        carryOut = fileVal[7];
      end
      rsa_pkg::OP_ROR: begin
        result = {carryIn, fileVal[7:1]};
        carryOut = fileVal[0];
      end
      rsa_pkg::OP_SUB: begin
        result = byteDiff[7:0];
        carryOut = ~byteDiff[8];
        nibbleOut = ~nibDiff[8];
        zeroOut = byteDiff[7:0] == 8'h00;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

endmodule : rsa_alu

// File: logic/rsa_alu_top.sv
/*
  Rotate/subtract datapath slice with its accumulator, flags and a 128-byte
  file register array, reached over an AHB-Lite slave port.
  Assumes a single master, word transfers only; every data phase has one wait state.
*/
// Chosen here: the address map and register access over AHB-Lite.
module rsa_alu_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  rsa_pkg::rsa_bus_t busState;
  rsa_pkg::rsa_exe_t exeState;
  logic [11:0] addrQ;
  logic writeQ;
  logic wordQ;
  logic accept;
  logic accessNow;
  logic busWr;
  logic execNow;
  logic [31:0] readMux;

  logic [13:0] instrReg;
  logic [7:0] acc;
  logic carry;
  logic nibbleCarry;
  logic zero;
  logic [7:0] lastResult;
  rsa_pkg::rsa_op_t lastOp;
  logic lastBad;
  logic [15:0] execCount;
  logic [7:0] fileMem [rsa_pkg::FILE_DEPTH];

  rsa_pkg::rsa_op_t opKind;
  logic destFile;
  logic [6:0] fileAddr;
  logic [7:0] literal;
  logic [7:0] fileVal;
  logic [7:0] aluResult;
  logic aluCarry;
  logic aluNibble;
  logic aluZero;
  logic isRotate;
  logic writesAcc;
  logic writesFile;

  // Address phase is taken only while the bus is ready and a NONSEQ/SEQ is shown
  assign accept = hsel && htrans[1] && hready;
  assign accessNow = busState == rsa_pkg::BUS_ACCESS;
  // Narrower writes are dropped so a partial store cannot corrupt a register
  assign busWr = accessNow && writeQ && wordQ;
  assign execNow = exeState == rsa_pkg::EXE_RUN;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busState <= rsa_pkg::BUS_IDLE;
      hreadyout <= 1'b1;
      addrQ <= 12'h000;
      writeQ <= 1'b0;
      wordQ <= 1'b0;
    end else begin
      case (busState)
        rsa_pkg::BUS_IDLE: begin
          if (accept) begin
            addrQ <= haddr[11:0];
            writeQ <= hwrite;
            wordQ <= hsize == rsa_pkg::SIZE_WORD;
            hreadyout <= 1'b0;
            busState <= rsa_pkg::BUS_ACCESS;
          end
        end
        rsa_pkg::BUS_ACCESS: begin
          hreadyout <= 1'b1;
          busState <= rsa_pkg::BUS_IDLE;
        end
        default: begin
          hreadyout <= 1'b1;
          busState <= rsa_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Every transfer completes OKAY; unmapped reads return zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hresp <= rsa_pkg::RESP_OKAY;
    end else begin
      hresp <= rsa_pkg::RESP_OKAY;
    end
  end

  always_comb begin
    readMux = 32'h0000_0000;
    if (rsa_pkg::fileHit(addrQ)) begin
      readMux = {24'h00_0000, fileMem[rsa_pkg::fileIdx(addrQ)]};
    end else begin
      case (addrQ)
        rsa_pkg::OFS_INSTR: readMux = {18'h0_0000, instrReg};
        rsa_pkg::OFS_ACC: readMux = {24'h00_0000, acc};
        rsa_pkg::OFS_FLAGS: readMux = {29'h0000_0000, zero, nibbleCarry, carry};
        rsa_pkg::OFS_LAST: readMux = {21'h00_0000, lastBad, lastOp, lastResult};
        rsa_pkg::OFS_COUNT: readMux = {16'h0000, execCount};
        default: readMux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (accessNow && !writeQ) begin
      hrdata <= readMux;
    end
  end

  // Writing the instruction register launches exactly one execution cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      instrReg <= rsa_pkg::RST_INSTR;
    end else if (busWr && addrQ == rsa_pkg::OFS_INSTR) begin
      instrReg <= hwdata[13:0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      exeState <= rsa_pkg::EXE_IDLE;
    end else begin
      case (exeState)
        rsa_pkg::EXE_IDLE: begin
          if (busWr && addrQ == rsa_pkg::OFS_INSTR) begin
            exeState <= rsa_pkg::EXE_RUN;
          end
        end
        rsa_pkg::EXE_RUN: exeState <= rsa_pkg::EXE_IDLE;
        default: exeState <= rsa_pkg::EXE_IDLE;
      endcase
    end
  end

  rsa_decode u_decode (
    .instrWord(instrReg),
    .opKind(opKind),
    .destFile(destFile),
    .fileAddr(fileAddr),
    .literal(literal)
  );

  assign fileVal = fileMem[fileAddr];

  rsa_alu u_alu (
    .opKind(opKind),
    .fileVal(fileVal),
    .accVal(acc),
    .literal(literal),
    .carryIn(carry),
    .result(aluResult),
    .carryOut(aluCarry),
    .nibbleOut(aluNibble),
    .zeroOut(aluZero)
  );

  assign isRotate = opKind == rsa_pkg::OP_ROL || opKind == rsa_pkg::OP_ROR;
  assign writesAcc = opKind == rsa_pkg::OP_SUB || (isRotate && !destFile);
  assign writesFile = isRotate && destFile;

  // Execution has priority, though the bus cannot reach a register in that cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      acc <= rsa_pkg::RST_ACC;
    end else if (execNow && writesAcc) begin
      acc <= aluResult;
    end else if (busWr && addrQ == rsa_pkg::OFS_ACC) begin
      acc <= hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      carry <= rsa_pkg::RST_FLAG;
    end else if (execNow && opKind != rsa_pkg::OP_NONE) begin
      carry <= aluCarry;
    end else if (busWr && addrQ == rsa_pkg::OFS_FLAGS) begin
      carry <= hwdata[rsa_pkg::FLAG_C];
    end
  end

  // Rotates leave the nibble carry and zero flags alone
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      nibbleCarry <= rsa_pkg::RST_FLAG;
      zero <= rsa_pkg::RST_FLAG;
    end else if (execNow && opKind == rsa_pkg::OP_SUB) begin
      nibbleCarry <= aluNibble;
      zero <= aluZero;
    end else if (busWr && addrQ == rsa_pkg::OFS_FLAGS) begin
      nibbleCarry <= hwdata[rsa_pkg::FLAG_NIBBLE];
      zero <= hwdata[rsa_pkg::FLAG_Z];
    end
  end

  // Data array carries no reset; software initialises it before use
  always_ff @(posedge sys_clk) begin
    if (execNow && writesFile) begin
      fileMem[fileAddr] <= aluResult;
    end else if (busWr && rsa_pkg::fileHit(addrQ)) begin
      fileMem[rsa_pkg::fileIdx(addrQ)] <= hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lastResult <= 8'h00;
      lastOp <= rsa_pkg::OP_NONE;
      lastBad <= 1'b0;
    end else if (execNow) begin
      lastResult <= aluResult;
      lastOp <= opKind;
      lastBad <= opKind == rsa_pkg::OP_NONE;
    end
  end

  // Wraps silently; software takes differences between two reads
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      execCount <= rsa_pkg::RST_COUNT;
    end else if (execNow && opKind != rsa_pkg::OP_NONE) begin
      execCount <= execCount + 16'h0001;
    end
  end

  // Expected values for the checks below
  logic [7:0] expRol;
  logic [7:0] expRor;
  logic [7:0] expSub;
  logic expNoBorrow;
  logic expNibble;

  assign expRol = {fileVal[6:0], carry};
  assign expRor = {carry, fileVal[7:1]};
  assign expSub = literal - acc;
  assign expNoBorrow = literal >= acc;
  assign expNibble = literal[3:0] >= acc[3:0];

  a_rol_result:
  assert property (@(posedge sys_clk) disable iff (reset)
    execNow && opKind == rsa_pkg::OP_ROL
    |=> (destFile ? fileVal : acc) == $past(expRol) && carry == $past(fileVal[7]))
    else $error("left rotate result or carry wrong");

  a_ror_result:
  assert property (@(posedge sys_clk) disable iff (reset)
    execNow && opKind == rsa_pkg::OP_ROR
    |=> (destFile ? fileVal : acc) == $past(expRor) && carry == $past(fileVal[0]))
    else $error("right rotate result or carry wrong");

  a_rot_to_acc:
  assert property (@(posedge sys_clk) disable iff (reset)
    execNow && isRotate && !destFile |=> fileVal == $past(fileVal))
    else $error("rotate to accumulator changed the file register");

  a_rot_to_file:
  assert property (@(posedge sys_clk) disable iff (reset)
    execNow && isRotate && destFile |=> $stable(acc))
    else $error("rotate to file register changed the accumulator");

  a_sub_value:
  assert property (@(posedge sys_clk) disable iff (reset)
    execNow && opKind == rsa_pkg::OP_SUB |=> acc == $past(expSub))
    else $error("literal minus accumulator wrong");

  a_sub_file_kept:
  assert property (@(posedge sys_clk) disable iff (reset)
    execNow && opKind == rsa_pkg::OP_SUB |=> fileVal == $past(fileVal))
    else $error("subtract touched a file register");

  a_rot_flags_kept:
  assert property (@(posedge sys_clk) disable iff (reset)
    execNow && isRotate |=> $stable(nibbleCarry) && $stable(zero))
    else $error("rotate changed nibble carry or zero");

  a_sub_flags:
  assert property (@(posedge sys_clk) disable iff (reset)
    execNow && opKind == rsa_pkg::OP_SUB
    |=> carry == $past(expNoBorrow) && nibbleCarry == $past(expNibble) && zero == (acc == 8'h00))
    else $error("subtract flags wrong");

  a_bus_wait_state:
  assert property (@(posedge sys_clk) disable iff (reset)
    accept && busState == rsa_pkg::BUS_IDLE |=> !hreadyout ##1 hreadyout)
    else $error("data phase not exactly one wait state");

  a_exec_once:
  assert property (@(posedge sys_clk) disable iff (reset)
    busWr && addrQ == rsa_pkg::OFS_INSTR |=> execNow ##1 !execNow)
    else $error("instruction write did not execute once");

endmodule : rsa_alu_top

// File: logic/rsa_decode.sv
/*
  Instruction decoder: splits the 14-bit instruction into operation, destination,
  file address and literal. Assumes a stable instruction word from the core.
*/
module rsa_decode (
  input wire logic [13:0] instrWord,
  output rsa_pkg::rsa_op_t opKind,
  output logic destFile,
  output logic [6:0] fileAddr,
  output logic [7:0] literal
);

  always_comb begin
    opKind = rsa_pkg::OP_NONE;
    if (instrWord[rsa_pkg::OPC_MSB:rsa_pkg::OPC_ROT_LSB] == rsa_pkg::OPC_ROL) begin
      opKind = rsa_pkg::OP_ROL;
    end else if (instrWord[rsa_pkg::OPC_MSB:rsa_pkg::OPC_ROT_LSB] == rsa_pkg::OPC_ROR) begin
      opKind = rsa_pkg::OP_ROR;
    end else if (instrWord[rsa_pkg::OPC_MSB:rsa_pkg::OPC_SUB_LSB] == rsa_pkg::OPC_SUB) begin
      // Bit 8 is a don't-care in the subtract pattern
      opKind = rsa_pkg::OP_SUB;
    end
  end

  assign destFile = instrWord[rsa_pkg::DEST_BIT];
  assign fileAddr = instrWord[rsa_pkg::FILE_MSB:0];
  assign literal = instrWord[rsa_pkg::LIT_MSB:0];

endmodule : rsa_decode
